// ---- scw_pkg.sv ----
// constants, encodings and states of the smbus configuration write slave
// assumes a single 200 mhz system clock
package scw_pkg;
    localparam logic [6:0]  SLAVE_ADDR    = 7'h0c;
    localparam int          BIT_CMD_BEGIN = 7;
    localparam int          BIT_CMD_END   = 6;
    localparam int          BIT_CMD_PEC   = 4;
    localparam int          ICMD_LSB      = 2;
    localparam int          SMB_LSB       = 0;
    localparam logic [1:0]  SMB_BYTE      = 2'h0;
    localparam logic [1:0]  SMB_WORD      = 2'h1;
    localparam logic [1:0]  SMB_BLOCK     = 2'h2;
    localparam logic [1:0]  ICMD_RD_DW    = 2'h0;
    localparam logic [1:0]  ICMD_WR_B     = 2'h1;
    localparam logic [1:0]  ICMD_WR_W     = 2'h2;
    localparam logic [1:0]  ICMD_WR_DW    = 2'h3;
    localparam logic [7:0]  LEN_BYTE      = 8'h01;
    localparam logic [7:0]  LEN_WORD      = 8'h02;
    localparam logic [7:0]  LEN_NONE      = 8'h00;
    localparam logic [7:0]  CRC_POLY      = 8'h07;
    localparam logic [7:0]  CRC_INIT      = 8'h00;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam longint      CLK_HZ        = 200_000_000;
    localparam longint      MS_PER_S      = 1000;
    localparam longint      LOW_TMO_MS    = 25;
    localparam longint      HIGH_TMO_MS   = 50;
    localparam longint      LOW_TMO_CYC   = LOW_TMO_MS * CLK_HZ / MS_PER_S;
    localparam longint      HIGH_TMO_CYC  = HIGH_TMO_MS * CLK_HZ / MS_PER_S;
    localparam int          TMO_W         = 24;
    localparam logic [TMO_W-1:0] TMO_ONE  = 24'h000001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD  = 3'b010,
        ST_CNT  = 3'b011,
        ST_DATA = 3'b100,
        ST_PEC  = 3'b101,
        ST_WAIT = 3'b110,
        ST_SKIP = 3'b111
    } scw_state_e;
endpackage

// ---- scw_smbus_cfg_wr.sv ----
// smbus slave that collects a configuration write and launches it internally
// assumes scl and sda pins are resolved outside; cfg done/err on i_clk_sys
module scw_smbus_cfg_wr
    import scw_pkg::*;
#(
    parameter logic [TMO_W-1:0] P_LOW_CYC  = TMO_W'(LOW_TMO_CYC),
    parameter logic [TMO_W-1:0] P_HIGH_CYC = TMO_W'(HIGH_TMO_CYC)
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_clk_en,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_scl,
    output logic             o_scl_oe_n,
    output logic             o_sda,
    output logic             o_sda_oe_n,
    output logic             o_cfg_req,
    output logic [1:0]       o_cfg_cmd,
    output logic [7:0]       o_cfg_bus,
    output logic [7:0]       o_cfg_devfn,
    output logic [15:0]      o_cfg_reg,
    output logic [31:0]      o_cfg_data,
    input  wire logic        i_cfg_done,
    input  wire logic        i_cfg_err
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
        end
        return x;
    endfunction

    function automatic logic [15:0] align_reg(input logic [15:0] r, input logic [1:0] ic);
        logic [15:0] a;
        a = r;
        if (ic == ICMD_WR_DW || ic == ICMD_RD_DW) begin
            a = {r[15:2], 2'h0};
        end else if (ic == ICMD_WR_W) begin
            a = {r[15:1], 1'h0};
        end
        return a;
    endfunction

    // ****************************************
    // pin synchronisers and bus events
    // ****************************************
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            o_scl                 <= 1'b0;
            o_sda                 <= 1'b0;
        end else if (i_clk_en) begin
            scl_m <= i_scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= i_sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
            o_scl <= 1'b0;
            o_sda <= 1'b0;
        end
    end

    wire start_c = scl_s && scl_d && sda_d && !sda_s;
    wire stop_c  = scl_s && scl_d && !sda_d && sda_s;
    wire rise_c  = scl_s && !scl_d;
    wire fall_c  = !scl_s && scl_d;

    // ****************************************
    // bit reception
    // ****************************************
    logic [3:0]  bit_cnt;
    logic [7:0]  rx;
    logic        in_ack;
    logic        tmo;
    scw_state_e  state;

    wire byte_done = fall_c && (bit_cnt == BITS_PER_BYTE) && !in_ack;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            bit_cnt <= 4'h0;
            rx      <= 8'h00;
            in_ack  <= 1'b0;
        end else if (i_clk_en) begin
            if (start_c || stop_c || tmo) begin
                bit_cnt <= 4'h0;
                in_ack  <= 1'b0;
            end else if (rise_c && !in_ack && bit_cnt < BITS_PER_BYTE) begin
                rx      <= {rx[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
                in_ack <= 1'b1;
            end else if (fall_c && in_ack && state != ST_WAIT) begin
                in_ack  <= 1'b0;
                bit_cnt <= 4'h0;
            end
        end
    end

    // ****************************************
    // transaction state machine
    // ****************************************
    logic [7:0]  cmd;
    logic [7:0]  remain;
    logic [7:0]  crc;
    logic [63:0] sh;
    logic [63:0] next_sh;
    logic        launch;

    wire        is_end  = cmd[BIT_CMD_END];
    wire        packet_check_enable  = cmd[BIT_CMD_PEC];
    wire [7:0]  crc_nx  = crc8(crc, rx);
    wire        pec_ok  = (rx == crc);
    wire        last_dt = (state == ST_DATA) && (remain == LEN_BYTE);

    always_comb begin
        next_sh = sh;
        if (byte_done && state == ST_DATA) begin
            next_sh = {sh[55:0], rx};
        end
        launch = byte_done && is_end &&
                 ((last_dt && !packet_check_enable) || (state == ST_PEC && pec_ok));
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state      <= ST_IDLE;
            cmd        <= 8'h00;
            remain     <= LEN_NONE;
            crc        <= CRC_INIT;
            sh         <= 64'h0;
            o_sda_oe_n <= 1'b1;
            o_scl_oe_n <= 1'b1;
        end else if (i_clk_en) begin
            if (tmo || stop_c) begin
                state      <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
                o_scl_oe_n <= 1'b1;
            end else if (start_c) begin
                state      <= ST_ADDR;
                crc        <= CRC_INIT;
                o_sda_oe_n <= 1'b1;
            end else if (state == ST_WAIT) begin
                if (i_cfg_done) begin
                    o_sda_oe_n <= i_cfg_err;
                    o_scl_oe_n <= 1'b1;
                    state      <= ST_SKIP;
                end
            end else if (byte_done) begin
                crc        <= crc_nx;
                o_sda_oe_n <= 1'b1;
                case (state)
                    ST_ADDR: begin
                        if (rx == {SLAVE_ADDR, 1'b0}) begin
                            o_sda_oe_n <= 1'b0;
                            state      <= ST_CMD;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                    ST_CMD: begin
                        cmd        <= rx;
                        o_sda_oe_n <= 1'b0;
                        case (rx[SMB_LSB+:2])
                            SMB_BLOCK: state <= ST_CNT;
                            SMB_WORD: begin
                                remain <= LEN_WORD;
                                state  <= ST_DATA;
                            end
                            SMB_BYTE: begin
                                remain <= LEN_BYTE;
                                state  <= ST_DATA;
                            end
                            default: begin
                                o_sda_oe_n <= 1'b1;
                                state      <= ST_SKIP;
                            end
                        endcase
                    end
                    ST_CNT: begin
                        if (rx != LEN_NONE) begin
                            remain     <= rx;
                            o_sda_oe_n <= 1'b0;
                            state      <= ST_DATA;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                    ST_DATA: begin
                        sh         <= next_sh;
                        remain     <= remain - LEN_BYTE;
                        o_sda_oe_n <= 1'b0;
                        if (last_dt) begin
                            if (packet_check_enable) begin
                                state <= ST_PEC;
                            end else if (is_end) begin
                                o_sda_oe_n <= 1'b1;
                                o_scl_oe_n <= 1'b0;
                                state      <= ST_WAIT;
                            end else begin
                                state <= ST_SKIP;
                            end
                        end
                    end
                    ST_PEC: begin
                        if (pec_ok && is_end) begin
                            o_scl_oe_n <= 1'b0;
                            state      <= ST_WAIT;
                        end else if (pec_ok) begin
                            o_sda_oe_n <= 1'b0;
                            state      <= ST_SKIP;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                    default: state <= state;
                endcase
            end else if (fall_c && in_ack) begin
                o_sda_oe_n <= 1'b1;
            end
        end
    end

    // ****************************************
    // internal configuration request
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cfg_req   <= 1'b0;
            o_cfg_cmd   <= ICMD_RD_DW;
            o_cfg_bus   <= 8'h00;
            o_cfg_devfn <= 8'h00;
            o_cfg_reg   <= 16'h0000;
            o_cfg_data  <= 32'h0;
        end else if (i_clk_en) begin
            if (launch) begin
                o_cfg_req <= 1'b1;
                o_cfg_cmd <= cmd[ICMD_LSB+:2];
                if (cmd[ICMD_LSB+:2] == ICMD_RD_DW) begin
                    o_cfg_bus   <= next_sh[31:24];
                    o_cfg_devfn <= next_sh[23:16];
                    o_cfg_reg   <= align_reg(next_sh[15:0], ICMD_RD_DW);
                    o_cfg_data  <= 32'h0;
                end else begin
                    o_cfg_bus   <= next_sh[63:56];
                    o_cfg_devfn <= next_sh[55:48];
                    o_cfg_reg   <= align_reg(next_sh[47:32], cmd[ICMD_LSB+:2]);
                    o_cfg_data  <= next_sh[31:0];
                end
            end else if (i_cfg_done) begin
                o_cfg_req <= 1'b0;
            end
        end
    end

    // ****************************************
    // scl timeouts
    // ****************************************
    logic             in_frame;
    logic [TMO_W-1:0] low_cnt;
    logic [TMO_W-1:0] high_cnt;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            in_frame <= 1'b0;
            low_cnt  <= '0;
            high_cnt <= '0;
            tmo      <= 1'b0;
        end else if (i_clk_en) begin
            tmo <= 1'b0;
            if (start_c) begin
                in_frame <= 1'b1;
                low_cnt  <= '0;
            end else if (stop_c) begin
                in_frame <= 1'b0;
                low_cnt  <= '0;
            end else if (in_frame && !scl_s && o_scl_oe_n) begin
                if (low_cnt == P_LOW_CYC - TMO_ONE) begin
                    tmo      <= 1'b1;
                    in_frame <= 1'b0;
                    low_cnt  <= '0;
                end else begin
                    low_cnt <= low_cnt + TMO_ONE;
                end
            end
            if (!scl_s) begin
                high_cnt <= '0;
            end else if (high_cnt == P_HIGH_CYC - TMO_ONE) begin
                tmo      <= 1'b1;
                high_cnt <= '0;
            end else begin
                high_cnt <= high_cnt + TMO_ONE;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence s_final_end;
        launch && i_clk_en && !tmo;
    endsequence
    sequence s_held;
        o_cfg_req && !o_scl_oe_n && state == ST_WAIT;
    endsequence

    addr_ack_a: assert property (
        byte_done && i_clk_en && !tmo && !stop_c && state == ST_ADDR && rx == {SLAVE_ADDR, 1'b0}
        |=> !o_sda_oe_n && state == ST_CMD) else $error("own address not acknowledged");
    addr_skip_a: assert property (
        byte_done && i_clk_en && !tmo && !stop_c && state == ST_ADDR && rx != {SLAVE_ADDR, 1'b0}
        |=> o_sda_oe_n && state == ST_SKIP) else $error("foreign address acknowledged");
    launch_req_a: assert property (
        s_final_end |=> s_held) else $error("end write did not launch");
    stretch_hold_a: assert property (
        state == ST_WAIT |-> !o_scl_oe_n && o_sda_oe_n) else $error("scl released early");
    err_nack_a: assert property (
        state == ST_WAIT && i_clk_en && !tmo && i_cfg_done && i_cfg_err
        |=> o_sda_oe_n && o_scl_oe_n && !o_cfg_req) else $error("failed write acknowledged");
    rd_err_a: assert property (
        state == ST_WAIT && i_clk_en && !tmo && i_cfg_done && i_cfg_err && o_cfg_cmd == ICMD_RD_DW
        |=> o_sda_oe_n) else $error("failed read access acknowledged");
    pec_nack_a: assert property (
        byte_done && i_clk_en && !tmo && !stop_c && state == ST_PEC && rx != crc
        |=> o_sda_oe_n && state == ST_SKIP ##1 o_sda_oe_n) else $error("bad pec acknowledged");
    dw_align_a: assert property (
        $rose(o_cfg_req) && o_cfg_cmd == ICMD_WR_DW |-> o_cfg_reg[1:0] == 2'h0)
        else $error("dword register not aligned");
    byte_reg_a: assert property (
        $rose(o_cfg_req) && o_cfg_cmd == ICMD_WR_B |-> o_cfg_reg == $past(next_sh[47:32]))
        else $error("byte register number altered");
    low_tmo_a: assert property (
        i_clk_en && !start_c && !stop_c && in_frame && !scl_s && o_scl_oe_n
        && low_cnt == P_LOW_CYC - TMO_ONE |=> tmo ##1 (state == ST_IDLE || !$past(i_clk_en)))
        else $error("low timeout missed");
    high_tmo_a: assert property (
        i_clk_en && scl_s && high_cnt == P_HIGH_CYC - TMO_ONE |=> tmo)
        else $error("high timeout missed");
    tmo_idle_a: assert property (
        tmo && i_clk_en |=> state == ST_IDLE && o_scl_oe_n && o_sda_oe_n)
        else $error("timeout did not reset slave");

endmodule

// ---- scw_smb_master.sv ----
// smbus master model: start, stop, byte transfers and long scl holds
// assumes the bench resolves open-drain wires with pull-ups and feeds them back
module scw_smb_master #(
    parameter int P_HALF = 12
) (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_low,
    output logic      o_sda_low,
    output logic      o_hang
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
        o_hang    = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // release scl and wait out a stretch of up to 4000 cycles, then flag a hang
    task automatic rise_scl();
        int k;
        o_scl_low = 1'b0;
        k = 0;
        while (i_scl !== 1'b1 && k < 4000) begin
            @(posedge i_clk);
            k++;
        end
        if (k >= 4000) o_hang = 1'b1;
        tick(P_HALF);
    endtask

    task automatic put_bit(input logic b, output logic seen);
        o_sda_low = ~b;
        tick(P_HALF);
        rise_scl();
        seen = i_sda;
        o_scl_low = 1'b1;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic start();
        o_sda_low = 1'b0;
        o_scl_low = 1'b0;
        tick(P_HALF);
        o_sda_low = 1'b1;
        tick(P_HALF);
        o_scl_low = 1'b1;
    endtask

    task automatic stop();
        o_sda_low = 1'b1;
        tick(P_HALF);
        o_scl_low = 1'b0;
        tick(P_HALF);
        o_sda_low = 1'b0;
        tick(P_HALF);
    endtask

    // scl held at one level for n cycles
    task automatic hold(input logic lvl, input int n);
        tick(P_HALF);
        o_scl_low = ~lvl;
        tick(n);
        o_scl_low = 1'b1;
    endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the smbus configuration write slave
// assumes shortened timeout parameters and a bench-made internal responder
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import scw_pkg::*;

    localparam int LOW_C  = 3000;
    localparam int HIGH_C = 1000;
    localparam int LAT    = 40;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] dat;
        logic        bad;
        logic        err;
    } scw_row_s;

    // ************************************
    // sequences: cmd, data, bad pec, error
    // ************************************
    localparam scw_row_s ROWS [30] = '{
        {8'h9d, 16'h1234, 2'h0}, {8'h1d, 16'h5637, 2'h0}, {8'h1d, 16'ha1b2, 2'h0},
        {8'h5d, 16'hc3d4, 2'h0}, {8'h99, 16'h2048, 2'h0}, {8'h19, 16'h0a0f, 2'h0},
        {8'h19, 16'h1122, 2'h0}, {8'h59, 16'h3344, 2'h0}, {8'h9c, 16'h0007, 2'h0},
        {8'h1c, 16'h0009, 2'h0}, {8'h1c, 16'h0001, 2'h0}, {8'h1c, 16'h0023, 2'h0},
        {8'h1c, 16'h00de, 2'h0}, {8'h1c, 16'h00ad, 2'h0}, {8'h1c, 16'h00be, 2'h0},
        {8'h5c, 16'h00ef, 2'h0}, {8'h8c, 16'h00aa, 2'h0}, {8'h0e, 16'hbb01, 2'h0},
        {8'h0c, 16'h00ff, 2'h0}, {8'h0d, 16'h1357, 2'h0}, {8'h4e, 16'h9bdf, 2'h0},
        {8'h85, 16'h3c5a, 2'h0}, {8'h05, 16'h0103, 2'h0}, {8'h05, 16'h0000, 2'h0},
        {8'h45, 16'h0099, 2'h0}, {8'h5d, 16'hc3d4, 2'h1}, {8'h91, 16'h1234, 2'h0},
        {8'h51, 16'h5637, 2'h1}, {8'h5c, 16'h0077, 2'h2}, {8'h5c, 16'h0078, 2'h0}
    };

    logic        clk;
    logic        resetn;
    logic        scl_w;
    logic        sda_w;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        scl_o;
    logic        sda_o;
    logic        m_scl_low;
    logic        m_sda_low;
    logic        hang;
    logic        cfg_req;
    logic [1:0]  cfg_cmd;
    logic [7:0]  cfg_bus;
    logic [7:0]  cfg_devfn;
    logic [15:0] cfg_reg;
    logic [31:0] cfg_data;
    logic        cfg_done;
    logic        cfg_err;
    logic        resp_err;
    logic        ok;
    logic        last;
    logic        a;
    logic [63:0] sh;
    logic [65:0] got;
    int          launches;
    int          n_mismatch;
    int          checked;

    assign scl_w = ~m_scl_low & (scl_oe_n | scl_o);
    assign sda_w = ~m_sda_low & (sda_oe_n | sda_o);

    scw_smbus_cfg_wr #(
        .P_LOW_CYC  (24'(LOW_C)),
        .P_HIGH_CYC (24'(HIGH_C))
    ) scw_smbus_cfg_wr_inst (
        .i_clk_sys   (clk),
        .i_resetn    (resetn),
        .i_clk_en    (1'b1),
        .i_scl       (scl_w),
        .i_sda       (sda_w),
        .o_scl       (scl_o),
        .o_scl_oe_n  (scl_oe_n),
        .o_sda       (sda_o),
        .o_sda_oe_n  (sda_oe_n),
        .o_cfg_req   (cfg_req),
        .o_cfg_cmd   (cfg_cmd),
        .o_cfg_bus   (cfg_bus),
        .o_cfg_devfn (cfg_devfn),
        .o_cfg_reg   (cfg_reg),
        .o_cfg_data  (cfg_data),
        .i_cfg_done  (cfg_done),
        .i_cfg_err   (cfg_err)
    );

    scw_smb_master #(.P_HALF(12)) scw_smb_master_inst (
        .i_clk     (clk),
        .i_scl     (scl_w),
        .i_sda     (sda_w),
        .o_scl_low (m_scl_low),
        .o_sda_low (m_sda_low),
        .o_hang    (hang)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        return r;
    endfunction

    // ************************************
    // internal access responder
    // ************************************
    always @(posedge cfg_req) begin
        #1;
        launches++;
        got = {cfg_cmd, cfg_bus, cfg_devfn, cfg_reg, cfg_data};
        repeat (LAT / 2) @(posedge clk);
        chk(scl_oe_n, 1'b0);
        chk({scl_o, sda_o}, 2'b00);
        repeat (LAT / 2) @(posedge clk);
        #1;
        cfg_done = 1'b1;
        cfg_err = resp_err;
        @(posedge clk);
        #1;
        cfg_done = 1'b0;
        cfg_err = 1'b0;
    end

    always @(posedge hang) begin
        n_mismatch++;
        tally_and_finish();
    end

    // one whole write transaction with optional pec
    task automatic xact(input logic [7:0] cmd, input logic [15:0] dat, input logic bad);
        logic [7:0] q[$];
        logic [7:0] crc;
        logic       s;
        q = {8'h18, cmd};
        if (cmd[1:0] == SMB_BLOCK) q.push_back(LEN_WORD);
        if (cmd[1:0] != SMB_BYTE) q.push_back(dat[15:8]);
        q.push_back(dat[7:0]);
        crc = CRC_INIT;
        foreach (q[i]) crc = crc8(crc, q[i]);
        if (cmd[BIT_CMD_PEC]) q.push_back(crc ^ {7'h00, bad});
        ok = 1'b1;
        scw_smb_master_inst.start();
        foreach (q[i]) begin
            scw_smb_master_inst.put_byte(q[i], s);
            if (i < q.size() - 1) ok = ok & s;
            else last = s;
        end
        scw_smb_master_inst.stop();
    endtask

    task automatic run_row(input scw_row_s rw);
        int          n0;
        logic        fin;
        logic [31:0] fld;
        logic [15:0] msk;
        resp_err = rw.err;
        n0 = launches;
        xact(rw.cmd, rw.dat, rw.bad);
        if (rw.cmd[1:0] == SMB_BYTE) sh = {sh[55:0], rw.dat[7:0]};
        else sh = {sh[47:0], rw.dat};
        fin = rw.cmd[BIT_CMD_END] & ~rw.bad;
        chk({ok, last}, {1'b1, ~rw.bad & ~(fin & rw.err)});
        chk(launches - n0, fin);
        if (fin) begin
            fld = (rw.cmd[3:2] == ICMD_RD_DW) ? sh[31:0] : sh[63:32];
            msk = (rw.cmd[3:2] == ICMD_WR_B) ? 16'hffff :
                  (rw.cmd[3:2] == ICMD_WR_W) ? 16'hfffe : 16'hfffc;
            chk(got[65:32], {rw.cmd[3:2], fld[31:16], fld[15:0] & msk});
            if (rw.cmd[3:2] != ICMD_RD_DW) chk(got[31:0], sh[31:0]);
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        resetn = 1'b0;
        cfg_done = 1'b0;
        cfg_err = 1'b0;
        resp_err = 1'b0;
        sh = 64'h0;
        got = 66'h0;
        launches = 0;
        n_mismatch = 0;
        checked = 0;
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        // master redoes sequences whole; command field constant within each
        for (int r = 0; r < 30; r++) run_row(ROWS[r]);
        for (int i = 0; i < 2; i++) begin
            scw_smb_master_inst.start();
            scw_smb_master_inst.put_byte(i ? 8'h19 : 8'h1a, a);
            scw_smb_master_inst.stop();
            chk(a, 1'b0);
        end
        // reserved length code, empty block, byte beyond the last
        for (int i = 0; i < 3; i++) begin
            scw_smb_master_inst.start();
            scw_smb_master_inst.put_byte(8'h18, a);
            scw_smb_master_inst.put_byte(i == 0 ? 8'h0f : (i == 1 ? 8'h0e : 8'h0c), a);
            if (i > 0) scw_smb_master_inst.put_byte(i == 1 ? LEN_NONE : 8'h55, a);
            if (i > 1) scw_smb_master_inst.put_byte(8'h66, a);
            scw_smb_master_inst.stop();
            chk(a, 1'b0);
        end
        for (int i = 0; i < 2; i++) begin
            scw_smb_master_inst.start();
            scw_smb_master_inst.put_byte(8'h18, a);
            scw_smb_master_inst.hold(i[0], i ? HIGH_C + 100 : LOW_C + 100);
            scw_smb_master_inst.put_byte(8'h1c, a);
            scw_smb_master_inst.stop();
            chk(a, 1'b0);
        end
        resetn = 1'b0;
        got = 66'(launches);
        xact(8'h5c, 16'h0042, 1'b0);
        chk({ok, last, 32'(launches)}, {2'b00, got[31:0]});
        resetn = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        for (int r = 0; r < 4; r++) run_row(ROWS[r]);
        tally_and_finish();
    end
endmodule
